// ---- hw/uart_frame_pkg.sv ----
package uart_frame_pkg;

  // Register addresses on the register port
  localparam logic [7:0] ADDR_MODE    = 8'h90;
  localparam logic [7:0] ADDR_ERR     = 8'h91;
  localparam logic [7:0] ADDR_TXSTAT  = 8'h92;
  localparam logic [7:0] ADDR_RXBUF   = 8'h93;
  localparam logic [7:0] ADDR_TXBUF   = 8'h94;
  localparam logic [7:0] ADDR_DIV     = 8'h95;
  localparam logic [7:0] ADDR_CTRL    = 8'h96;

  // Mode register fields
  localparam int MODE_POWER     = 7;
  localparam int MODE_TXE       = 6;
  localparam int MODE_RXE       = 5;
  localparam int MODE_PS_HI     = 4;
  localparam int MODE_PS_LO     = 3;
  localparam int MODE_LEN8      = 2;
  localparam int MODE_STOP2     = 1;
  localparam int MODE_ERR_MERGE = 0;

  // Control register fields
  localparam int CTRL_DIR = 1;
  localparam int CTRL_INV = 0;

  // Status register fields
  localparam int ERR_PE      = 2;
  localparam int ERR_FE      = 1;
  localparam int ERR_OVE     = 0;
  localparam int TXSTAT_FULL = 1;
  localparam int TXSTAT_BUSY = 0;

  // Values after reset
  localparam logic [7:0] MODE_RST  = 8'h01;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DIV_RST   = 8'hff;
  localparam logic [7:0] RXBUF_RST = 8'hff;

  // Parity select codes {hi, lo}
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // Frame and counter sizes
  localparam int FRAME_MAX = 12;
  localparam int RXSH_W    = 10;
  localparam int CNT_W     = 9;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

endpackage : uart_frame_pkg

// ---- hw/serial_in_sync.sv ----
// Three-stage input synchroniser; level moves only when stages two and three agree
module serial_in_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // Pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_st_t;

  sync_st_t st_reg;
  sync_st_t st_next;

  // Stage one feeds stage two only, so metastability stays contained
  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.level = st_reg.s3;
    end
  end

  // Idle line is high, so reset to high
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_reg <= 4'hf;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.level;

endmodule : serial_in_sync

// ---- hw/uart_frame_txrx_core.sv ----
module uart_frame_txrx_core (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  // Register port
  input  wire uart_frame_pkg::reg_req_t i_reg_req,
  output logic [7:0]                    o_reg_rdata,
  // Serial pins
  input  wire logic                     i_serial_in,
  output logic                          o_serial_out,
  // Event pulses
  output logic                          o_tx_done_irq,
  output logic                          o_rx_done_irq,
  output logic                          o_rx_error_irq
);

  typedef struct packed {
    logic [7:0]                            mode;
    logic [7:0]                            ctrl;
    logic [7:0]                            divisor;
    logic [7:0]                            tx_buf;
    logic                                  tx_full;
    logic                                  tx_busy;
    logic [uart_frame_pkg::FRAME_MAX-1:0]  tx_frame;
    logic [3:0]                            tx_left;
    logic [uart_frame_pkg::CNT_W-1:0]      tx_cnt;
    uart_frame_pkg::rx_state_t             rx_state;
    logic [uart_frame_pkg::CNT_W-1:0]      rx_cnt;
    logic [3:0]                            rx_bits;
    logic [uart_frame_pkg::RXSH_W-1:0]     rx_sh;
    logic                                  rx_prev;
    logic [7:0]                            rx_buf;
    logic                                  rx_unread;
    logic [2:0]                            err;
    logic [7:0]                            rdata;
    logic                                  pin;
    logic                                  tx_done;
    logic                                  rx_done;
    logic                                  rx_error;
  } core_st_t;

  core_st_t st_reg;
  core_st_t st_next;
  logic     rx_level;

  // Frame length in bits including start
  function automatic logic [3:0] frame_len(input logic len8, input logic has_par,
                                           input logic stop2);
    frame_len = 4'd1 + (len8 ? 4'd8 : 4'd7) + (has_par ? 4'd1 : 4'd0)
              + (stop2 ? 4'd2 : 4'd1);
  endfunction : frame_len

  // Reorders character bits into line order; the mapping is its own inverse
  function automatic logic [7:0] bit_order(input logic [7:0] d, input logic len8,
                                           input logic msb);
    logic [7:0] r;
    r = len8 ? d : {1'b0, d[6:0]};
    if (msb)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (len8)
        begin
          r[i] = d[7-i];
        end
        else if (i < 7)
        begin
          r[i] = d[6-i];
        end
      end
    end
    bit_order = r;
  endfunction : bit_order

  // Odd count of ones in the character
  function automatic logic ones_odd(input logic [7:0] d, input logic len8);
    ones_odd = len8 ? ^d : ^d[6:0];
  endfunction : ones_odd

  // Receive pin passes the three-stage synchroniser
  serial_in_sync u_rx_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_pin    (i_serial_in),
    .o_level  (rx_level)
  );

  // Whole next-state computation
  always_comb
  begin
    logic                                 power;
    logic                                 len8;
    logic                                 msb;
    logic [1:0]                           par;
    logic                                 has_par;
    logic [uart_frame_pkg::CNT_W-1:0]     period;
    logic [uart_frame_pkg::CNT_W-1:0]     half;
    logic                                 lvl;
    logic [7:0]                           ord;
    logic [uart_frame_pkg::FRAME_MAX-1:0] frame;
    logic [3:0]                           dlen;
    logic [3:0]                           rx_last;
    logic [7:0]                           rx_data;
    logic                                 rx_par;
    logic                                 pe;
    logic                                 fe;
    logic                                 ove;
    logic                                 load;

    st_next          = st_reg;
    st_next.tx_done  = 1'b0;
    st_next.rx_done  = 1'b0;
    st_next.rx_error = 1'b0;
    power   = st_reg.mode[uart_frame_pkg::MODE_POWER];
    len8    = st_reg.mode[uart_frame_pkg::MODE_LEN8];
    msb     = st_reg.ctrl[uart_frame_pkg::CTRL_DIR];
    par     = {st_reg.mode[uart_frame_pkg::MODE_PS_HI], st_reg.mode[uart_frame_pkg::MODE_PS_LO]};
    has_par = (par != uart_frame_pkg::PAR_NONE);
    dlen    = len8 ? 4'd8 : 4'd7;
    // Bit time is twice the divisor; zero is treated as one to avoid a stuck counter
    half    = (st_reg.divisor == 8'h00) ? 9'h001 : {1'b0, st_reg.divisor};
    period  = {half[7:0], 1'b0};
    // Pin reads high while the unit is powered down
    lvl     = power ? rx_level : 1'b1;
    ord     = 8'h00;
    frame   = '1;
    rx_data = 8'h00;
    rx_par  = 1'b0;
    pe      = 1'b0;
    fe      = 1'b0;
    ove     = 1'b0;
    load    = 1'b0;
    rx_last = 4'(frame_len(len8, has_par, 1'b0) - 4'd2);

    // Register reads; status reads carry their side effects
    if (i_reg_req.rd)
    begin
      case (i_reg_req.addr)
        uart_frame_pkg::ADDR_MODE:   st_next.rdata = st_reg.mode;
        uart_frame_pkg::ADDR_ERR:
        begin
          st_next.rdata = {5'h00, st_reg.err};
          st_next.err   = 3'h0;
        end
        uart_frame_pkg::ADDR_TXSTAT:
          st_next.rdata = {6'h00, st_reg.tx_full, st_reg.tx_busy};
        uart_frame_pkg::ADDR_RXBUF:
        begin
          st_next.rdata     = st_reg.rx_buf;
          st_next.rx_unread = 1'b0;
        end
        uart_frame_pkg::ADDR_TXBUF:  st_next.rdata = st_reg.tx_buf;
        uart_frame_pkg::ADDR_DIV:    st_next.rdata = st_reg.divisor;
        uart_frame_pkg::ADDR_CTRL:   st_next.rdata = {6'h00, st_reg.ctrl[1:0]};
        default:                     st_next.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (i_reg_req.wr)
    begin
      case (i_reg_req.addr)
        uart_frame_pkg::ADDR_MODE:   st_next.mode    = i_reg_req.wdata;
        uart_frame_pkg::ADDR_DIV:    st_next.divisor = i_reg_req.wdata;
        uart_frame_pkg::ADDR_CTRL:   st_next.ctrl    = {6'h00, i_reg_req.wdata[1:0]};
        uart_frame_pkg::ADDR_TXBUF:
        begin
          // Writing while full overwrites the waiting character
          if (power && st_reg.mode[uart_frame_pkg::MODE_TXE])
          begin
            st_next.tx_buf  = i_reg_req.wdata;
            st_next.tx_full = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Transmit shifter: one bit per bit time
    if (st_reg.tx_busy)
    begin
      if (st_reg.tx_cnt == period - 9'd1)
      begin
        st_next.tx_cnt   = '0;
        st_next.tx_frame = {1'b1, st_reg.tx_frame[uart_frame_pkg::FRAME_MAX-1:1]};
        st_next.tx_left  = st_reg.tx_left - 4'd1;
        if (st_reg.tx_left == 4'd1)
        begin
          st_next.tx_done = 1'b1;
          st_next.tx_busy = 1'b0;
          load            = st_reg.tx_full;
        end
      end
      else
      begin
        st_next.tx_cnt = st_reg.tx_cnt + 9'd1;
      end
    end
    else
    begin
      load = st_reg.tx_full;
    end

    // Buffer to shifter transfer with start, parity and stops added
    if (load)
    begin
      ord      = bit_order(st_reg.tx_buf, len8, msb);
      frame[0] = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        if (i < 7 || len8)
        begin
          frame[1+i] = ord[i];
        end
      end
      case (par)
        uart_frame_pkg::PAR_EVEN: frame[dlen+4'd1] = ones_odd(st_reg.tx_buf, len8);
        uart_frame_pkg::PAR_ODD:  frame[dlen+4'd1] = !ones_odd(st_reg.tx_buf, len8);
        uart_frame_pkg::PAR_ZERO: frame[dlen+4'd1] = 1'b0;
        default:
        begin
        end
      endcase
      st_next.tx_frame = frame;
      st_next.tx_left  = frame_len(len8, has_par, st_reg.mode[uart_frame_pkg::MODE_STOP2]);
      st_next.tx_cnt   = '0;
      st_next.tx_busy  = 1'b1;
      st_next.tx_full  = 1'b0;
    end

    // Receiver: edge, start check at half bit, then mid-bit samples
    st_next.rx_prev = lvl;
    case (st_reg.rx_state)
      uart_frame_pkg::RX_IDLE:
      begin
        if (st_reg.mode[uart_frame_pkg::MODE_RXE] && st_reg.rx_prev && !lvl)
        begin
          st_next.rx_state = uart_frame_pkg::RX_START;
          st_next.rx_cnt   = '0;
        end
      end
      uart_frame_pkg::RX_START:
      begin
        if (st_reg.rx_cnt == half - 9'd1)
        begin
          st_next.rx_cnt   = '0;
          st_next.rx_bits  = 4'd0;
          // A high level here was a glitch, so wait for the next edge
          st_next.rx_state = lvl ? uart_frame_pkg::RX_IDLE : uart_frame_pkg::RX_DATA;
        end
        else
        begin
          st_next.rx_cnt = st_reg.rx_cnt + 9'd1;
        end
      end
      uart_frame_pkg::RX_DATA:
      begin
        if (st_reg.rx_cnt == period - 9'd1)
        begin
          st_next.rx_cnt                = '0;
          st_next.rx_sh[st_reg.rx_bits] = lvl;
          st_next.rx_bits               = st_reg.rx_bits + 4'd1;
          if (st_reg.rx_bits == rx_last)
          begin
            rx_data = len8 ? st_reg.rx_sh[7:0] : {1'b0, st_reg.rx_sh[6:0]};
            rx_par  = len8 ? st_reg.rx_sh[8] : st_reg.rx_sh[7];
            case (par)
              uart_frame_pkg::PAR_EVEN: pe = ones_odd(rx_data, len8) ^ rx_par;
              uart_frame_pkg::PAR_ODD:  pe = !(ones_odd(rx_data, len8) ^ rx_par);
              default:                  pe = 1'b0;
            endcase
            fe  = !lvl;
            ove = st_next.rx_unread;
            if (!ove)
            begin
              st_next.rx_buf    = bit_order(rx_data, len8, msb);
              st_next.rx_unread = 1'b1;
            end
            // Flags set at frame end win over a clearing read in the same cycle
            st_next.err[uart_frame_pkg::ERR_PE]  = st_next.err[uart_frame_pkg::ERR_PE] | pe;
            st_next.err[uart_frame_pkg::ERR_FE]  = st_next.err[uart_frame_pkg::ERR_FE] | fe;
            st_next.err[uart_frame_pkg::ERR_OVE] = st_next.err[uart_frame_pkg::ERR_OVE] | ove;
            if ((pe || fe || ove) && !st_reg.mode[uart_frame_pkg::MODE_ERR_MERGE])
            begin
              st_next.rx_error = 1'b1;
            end
            else
            begin
              st_next.rx_done = 1'b1;
            end
            st_next.rx_state = uart_frame_pkg::RX_IDLE;
          end
        end
        else
        begin
          st_next.rx_cnt = st_reg.rx_cnt + 9'd1;
        end
      end
      default:
      begin
        st_next.rx_state = uart_frame_pkg::RX_IDLE;
      end
    endcase

    // Disables reset their circuits; power down also clears status and buffer
    if (!power || !st_reg.mode[uart_frame_pkg::MODE_TXE])
    begin
      st_next.tx_busy = 1'b0;
      st_next.tx_full = 1'b0;
      st_next.tx_cnt  = '0;
      st_next.tx_done = 1'b0;
    end
    if (!power || !st_reg.mode[uart_frame_pkg::MODE_RXE])
    begin
      st_next.rx_state = uart_frame_pkg::RX_IDLE;
      st_next.rx_cnt   = '0;
      st_next.rx_done  = 1'b0;
      st_next.rx_error = 1'b0;
    end
    if (!power)
    begin
      st_next.err       = 3'h0;
      st_next.rx_buf    = uart_frame_pkg::RXBUF_RST;
      st_next.rx_unread = 1'b0;
    end

    // Pin is high except while a frame is on the line
    st_next.pin = (power && st_next.tx_busy)
                ? (st_next.tx_frame[0] ^ st_reg.ctrl[uart_frame_pkg::CTRL_INV])
                : 1'b1;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_reg          <= '0;
      st_reg.mode     <= uart_frame_pkg::MODE_RST;
      st_reg.ctrl     <= uart_frame_pkg::CTRL_RST;
      st_reg.divisor  <= uart_frame_pkg::DIV_RST;
      st_reg.tx_frame <= '1;
      st_reg.rx_state <= uart_frame_pkg::RX_IDLE;
      st_reg.rx_prev  <= 1'b1;
      st_reg.rx_buf   <= uart_frame_pkg::RXBUF_RST;
      st_reg.pin      <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_reg_rdata    = st_reg.rdata;
  assign o_serial_out   = st_reg.pin;
  assign o_tx_done_irq  = st_reg.tx_done;
  assign o_rx_done_irq  = st_reg.rx_done;
  assign o_rx_error_irq = st_reg.rx_error;

endmodule : uart_frame_txrx_core

// ---- tb/uart_frame_monitor.sv ----
// Port-level checks; sees only the core's top-level ports
module uart_frame_monitor (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_arst_n,
  // Register port
  input wire uart_frame_pkg::reg_req_t i_reg_req,
  input wire logic [7:0]               o_reg_rdata,
  // Serial pins and events
  input wire logic                     i_serial_in,
  input wire logic                     o_serial_out,
  input wire logic                     o_tx_done_irq,
  input wire logic                     o_rx_done_irq,
  input wire logic                     o_rx_error_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Decoded reads and mode write; a receive event excuses a read that races a flag set
  wire logic rd_err = i_reg_req.rd && (i_reg_req.addr == uart_frame_pkg::ADDR_ERR);
  wire logic rd_rxb = i_reg_req.rd && (i_reg_req.addr == uart_frame_pkg::ADDR_RXBUF);
  wire logic rd_txs = i_reg_req.rd && (i_reg_req.addr == uart_frame_pkg::ADDR_TXSTAT);
  wire logic wr_mod = i_reg_req.wr && (i_reg_req.addr == uart_frame_pkg::ADDR_MODE);
  wire logic rd_mod = i_reg_req.rd && (i_reg_req.addr == uart_frame_pkg::ADDR_MODE);
  wire logic rx_ev  = o_rx_done_irq || o_rx_error_irq;

  a_err_read_clear: assert property (rd_err ##1 (rd_err && !rx_ev) |=>
    o_reg_rdata[2:0] == 3'h0) else $error("error flags survive a read");
  a_rxbuf_hold: assert property ((rd_rxb && !rx_ev) ##1 (rd_rxb && !rx_ev) |=>
    $stable(o_reg_rdata)) else $error("receive buffer changed without a frame");
  a_rdata_stands: assert property (!i_reg_req.rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_txstat_bits: assert property (rd_txs |=> o_reg_rdata[7:2] == 6'h00)
    else $error("transmit status upper bits set");
  a_mode_back: assert property (wr_mod ##1 (rd_mod && !i_reg_req.wr) |=>
    o_reg_rdata == $past(i_reg_req.wdata, 2)) else $error("mode readback wrong");
  a_tx_done_gap: assert property (o_tx_done_irq |=> !o_tx_done_irq [*8])
    else $error("transmit done too close");
  a_rx_irq_gap: assert property (rx_ev |=> !rx_ev [*8])
    else $error("receive events too close");
  a_rx_irq_excl: assert property (!(o_rx_done_irq && o_rx_error_irq))
    else $error("done and error together");

  // Main scenarios reached
  c_tx_done: cover property (o_tx_done_irq);
  c_rx_done: cover property (o_rx_done_irq);
  c_rx_err: cover property (o_rx_error_irq);
endmodule : uart_frame_monitor

// ---- tb/uart_remote_node.sv ----
// Far-end serial node; drives the core's receive pin after falling edges
module uart_remote_node (
  // Clock
  input  wire logic i_clk,
  // Line into the core
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_line = 1'b1;

  // One frame, index 0 first; line returns to mark level afterwards
  task automatic send(input logic [11:0] bits, input int n, input int bt);
    for (int k = 0; k < n; k++)
    begin
      o_line = bits[k];
      repeat (bt) @(negedge i_clk);
    end
    o_line = 1'b1;
  endtask : send

  // Low pulse shorter than the start check, must not start a frame
  task automatic glitch(input int len);
    o_line = 1'b0;
    repeat (len) @(negedge i_clk);
    o_line = 1'b1;
  endtask : glitch
endmodule : uart_remote_node

// ---- tb/test_uart_frame_txrx_core.sv ----
module test_uart_frame_txrx_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4; // Short divisor keeps each frame under 100 clocks
  localparam int BT  = 2 * DIV;

  logic                     i_clk;
  logic                     i_arst_n;
  uart_frame_pkg::reg_req_t req;
  logic [7:0]               rdata;
  logic                     ser_in;
  logic                     ser_out;
  logic                     tx_done;
  logic                     rx_done;
  logic                     rx_err;
  int                       n_errors;
  int                       samples_checked;
  logic [11:0]              fr;
  int                       fn;
  logic [7:0]               v;
  logic [7:0]               w;
  logic [2:0]               g;
  int                       cyc;
  logic [7:0]               ra [7] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97};
  logic [7:0]               rv [7] = '{8'h01, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

  uart_frame_txrx_core u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_req(req),
    .o_reg_rdata(rdata), .i_serial_in(ser_in), .o_serial_out(ser_out),
    .o_tx_done_irq(tx_done), .o_rx_done_irq(rx_done), .o_rx_error_irq(rx_err));
  uart_remote_node u_peer (.i_clk(i_clk), .o_line(ser_in));

  always #50 i_clk = ~i_clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  // Register access; called at a falling edge, returns at one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge i_clk);
    req.wr = 1'b0;
  endtask : wr

  // Two back-to-back reads with the strobe held high
  task automatic rd2(input logic [7:0] a1, input logic [7:0] a2, output logic [7:0] d1,
                     output logic [7:0] d2);
    req.addr = a1;
    req.rd = 1'b1;
    @(negedge i_clk);
    d1 = rdata;
    req.addr = a2;
    @(negedge i_clk);
    d2 = rdata;
    req.rd = 1'b0;
  endtask : rd2

  // Bounded wait for any selected event {error, done, tx done}
  task automatic wait_ev(input logic [2:0] sel);
    g = 3'h0;
    for (cyc = 0; cyc < 400 && g == 3'h0; cyc++)
    begin
      @(posedge i_clk);
      #1;
      g = sel & {rx_err, rx_done, tx_done};
    end
    @(negedge i_clk);
  endtask : wait_ev

  // Expected wire bits of one frame for a mode value
  task automatic mk_frame(input logic [7:0] d, input logic [7:0] m, input logic msb);
    int nd;
    nd = m[2] ? 8 : 7;
    fr = '1;
    fr[0] = 1'b0;
    for (int i = 0; i < nd; i++)
      fr[1 + i] = msb ? d[nd - 1 - i] : d[i];
    fn = nd + 1;
    if (m[4:3] != uart_frame_pkg::PAR_NONE)
    begin
      fr[fn] = (m[4:3] != uart_frame_pkg::PAR_ZERO) &&
        ((^(d & {m[2], 7'h7f})) ^ (m[4:3] == uart_frame_pkg::PAR_ODD));
      fn++;
    end
    fn += m[1] ? 2 : 1;
  endtask : mk_frame

  // Send one character and sample the pin near each bit centre
  task automatic tx_check(input logic [7:0] d, input logic [7:0] m, input logic [1:0] c);
    mk_frame(d, m, c[1]);
    wr(uart_frame_pkg::ADDR_TXBUF, d);
    repeat (DIV + 1) @(negedge i_clk);
    for (int k = 0; k < fn; k++)
    begin
      if (k != 0)
        repeat (BT) @(negedge i_clk);
      chk("tx bit", {7'h0, fr[k] ^ c[0]}, {7'h0, ser_out});
    end
    wait_ev(3'b001);
    chk("tx done", 8'h01, {7'h0, g[0]});
    chk("tx idle", 8'h01, {7'h0, ser_out});
  endtask : tx_check

  // Receive one frame (fl: 1 flips parity, 2 flips stop), then read status and buffer
  task automatic rx_check(input logic [7:0] d, input logic [7:0] m, input logic msb,
                          input int fl, input logic [2:0] ee, input logic [7:0] xd);
    mk_frame(d, m & 8'hfd, msb);
    if (fl != 0)
      fr[fn - 3 + fl] = ~fr[fn - 3 + fl];
    fork
      u_peer.send(fr, fn, BT);
      wait_ev(3'b110);
    join
    // Merge mode routes an errored frame to the completion pulse
    chk("rx event", {5'h0, ee != 3'h0 && !m[0], ee == 3'h0 || m[0], 1'b0}, {5'h0, g});
    chk("rx late", 8'h01, {7'h0, cyc >= (fn - 1) * BT});
    rd2(uart_frame_pkg::ADDR_ERR, uart_frame_pkg::ADDR_ERR, v, w);
    chk("err flags", {5'h0, ee}, v);
    chk("err cleared", 8'h00, w);
    // Idle cycle so the read strobe is never lowered and raised at once
    @(negedge i_clk);
    rd2(uart_frame_pkg::ADDR_RXBUF, uart_frame_pkg::ADDR_RXBUF, v, w);
    chk("rx data", xd, v);
  endtask : rx_check

  task automatic results();
    $display("mismatches %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial
  begin
    repeat (30000) @(posedge i_clk);
    n_errors++;
    results();
  end

  initial
  begin
    logic [7:0] m;
    logic [7:0] d;
    logic [1:0] c;
    i_clk = 1'b0;
    i_arst_n = 1'b0;
    req = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(negedge i_clk);
    i_arst_n = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd2(ra[i], ra[i], v, w);
      chk("reset value", rv[i], v);
      @(negedge i_clk);
    end
    wr(uart_frame_pkg::ADDR_DIV, 8'(DIV));
    @(negedge i_clk);
    wr(uart_frame_pkg::ADDR_MODE, 8'h80);
    chk("powered idle", 8'h01, {7'h0, ser_out});
    // Every parity code, both lengths, stop counts, bit orders and polarities
    for (int p = 0; p < 4; p++)
    begin
      m = 8'he0 | 8'(p << 3) | (p[1] ? 8'h04 : 8'h00) | (p[0] ? 8'h02 : 8'h00);
      c = {p[0] ^ p[1], p[1]};
      d = 8'h36 + 8'(8'h51 * p);
      wr(uart_frame_pkg::ADDR_CTRL, {6'h0, c});
      @(negedge i_clk);
      wr(uart_frame_pkg::ADDR_MODE, m);
      rd2(uart_frame_pkg::ADDR_MODE, uart_frame_pkg::ADDR_MODE, v, w);
      chk("mode", m, v);
      tx_check(d, m, c);
      rx_check(d, m, c[1], p != 0, p > 1 ? 3'h4 : 3'h0, d & {m[2], 7'h7f});
      rx_check(~d, m, c[1], 0, 3'h0, ~d & {m[2], 7'h7f});
    end
    // Short low pulse rejected at the start check
    u_peer.glitch(DIV / 2);
    wait_ev(3'b110);
    chk("glitch", 8'h00, {5'h0, g});
    rx_check(8'hc3, m, 1'b0, 2, 3'h2, 8'hc3);
    // Second frame lands before the buffer is read
    mk_frame(8'ha5, m, 1'b0);
    fork
      u_peer.send(fr, fn, BT);
      wait_ev(3'b110);
    join
    rx_check(8'h5a, m, 1'b0, 0, 3'h1, 8'ha5);
    // Errored frame reported as a plain completion when merging is on
    wr(uart_frame_pkg::ADDR_MODE, m | 8'h01);
    rx_check(8'h0f, m | 8'h01, 1'b0, 1, 3'h4, 8'h0f);
    // Continuous transmission through the flag pairs
    wr(uart_frame_pkg::ADDR_CTRL, 8'h00);
    @(negedge i_clk);
    wr(uart_frame_pkg::ADDR_TXBUF, 8'h11);
    rd2(uart_frame_pkg::ADDR_TXSTAT, uart_frame_pkg::ADDR_TXSTAT, v, w);
    chk("status 10", 8'h02, v);
    chk("status 01", 8'h01, w);
    wr(uart_frame_pkg::ADDR_TXBUF, 8'h22);
    rd2(uart_frame_pkg::ADDR_TXSTAT, uart_frame_pkg::ADDR_TXSTAT, v, w);
    chk("status 11", 8'h03, v);
    wait_ev(3'b001);
    chk("no gap start", 8'h00, {7'h0, ser_out});
    rd2(uart_frame_pkg::ADDR_TXSTAT, uart_frame_pkg::ADDR_TXSTAT, v, w);
    chk("status 01 again", 8'h01, v);
    wait_ev(3'b001);
    rd2(uart_frame_pkg::ADDR_TXSTAT, uart_frame_pkg::ADDR_TXSTAT, v, w);
    chk("status 00", 8'h00, v);
    results();
  end
endmodule : test_uart_frame_txrx_core

bind uart_frame_txrx_core uart_frame_monitor u_mon (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .i_serial_in(i_serial_in),
  .o_serial_out(o_serial_out), .o_tx_done_irq(o_tx_done_irq),
  .o_rx_done_irq(o_rx_done_irq), .o_rx_error_irq(o_rx_error_irq));
